// file: icr_pkg.sv
// Package for the interrupt clear register group: offsets, bit positions,
// reset values and the carrier types used by the top.
// Assumes a 32-bit register port with byte addresses.
package icr_pkg;
    localparam int unsigned ICR_ADDR_W = 8;
    localparam int unsigned ICR_DATA_W = 32;
    localparam int unsigned ICR_NUM_SRC = 8;
    localparam int unsigned ICR_ABRT_W = 16;

    // Byte offsets of the clear registers, of the status views and of the mask.
    localparam logic [7:0] ICR_OFF_CLR_ALL = 8'h40;
    localparam logic [7:0] ICR_OFF_RX_UNDER_CLEAR = 8'h44;
    localparam logic [7:0] ICR_OFF_RX_OVER_CLEAR = 8'h48;
    localparam logic [7:0] ICR_OFF_CLR_TX_OVER = 8'h4C;
    localparam logic [7:0] ICR_OFF_RAW_STATUS = 8'h34;
    localparam logic [7:0] ICR_OFF_ABRT_CAUSE = 8'h80;
    localparam logic [7:0] ICR_OFF_INTR_MASK = 8'h30;

    // Bit positions in the raw interrupt status.
    localparam int unsigned ICR_BIT_RX_UNDER = 0;
    localparam int unsigned ICR_BIT_RX_OVER = 1;
    localparam int unsigned ICR_BIT_TX_OVER = 3;

    // Values after reset.
    localparam logic [31:0] ICR_RST_ZERO = 32'h0000_0000;
    localparam logic [7:0] ICR_RST_MASK = 8'hFF;
    localparam logic [7:0] ICR_RST_RAW = 8'h00;
    localparam logic [15:0] ICR_RST_ABRT = 16'h0000;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } icr_req_t;

    typedef struct packed {
        logic [ICR_NUM_SRC-1:0] set;
        logic [ICR_ABRT_W-1:0] abrt_set;
    } icr_event_t;
endpackage : icr_pkg

// file: icr_flag.sv
// Holds one sticky interrupt source bit.
// Assumes set and clear are single-clock pulses from the core clock domain.
`timescale 1ns/1ps
module icr_flag
    import icr_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Control
    input wire logic i_set,
    input wire logic i_clr,
    // Status
    output logic o_flag
);
    logic flag_q;

    // An event in the clear cycle survives; set wins over clear.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            flag_q <= 1'b0;
        end else if (i_set) begin
            flag_q <= 1'b1;
        end else if (i_clr) begin
            flag_q <= 1'b0;
        end
    end

    assign o_flag = flag_q;
endmodule : icr_flag

// file: icr_top.sv
// Read-to-clear interrupt register group of a two-wire serial controller.
// Assumes event pulses from the protocol engine on the core clock and a
// register port whose read data is taken in the cycle after the strobe.
`timescale 1ns/1ps
module icr_top
    import icr_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_arst_n,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // Events from the protocol engine
    input wire logic [7:0] i_src_set,
    input wire logic [15:0] i_abrt_set,
    // Interrupt state
    output logic o_intr,
    output logic [7:0] o_raw_status,
    output logic [15:0] o_abrt_cause
);
    icr_req_t req;
    icr_event_t evt;
    logic [7:0] raw;
    logic [7:0] clr;
    logic [7:0] mask_q;
    logic [15:0] abrt_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic intr_q;
    logic [7:0] raw_q;
    logic rd_all;

    assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign evt = '{set: i_src_set, abrt_set: i_abrt_set};

    assign rd_all = req.rd && (req.addr == ICR_OFF_CLR_ALL);

    always_comb begin
        clr = {ICR_NUM_SRC{rd_all}};
        if (req.rd && req.addr == ICR_OFF_RX_UNDER_CLEAR) begin
            clr[ICR_BIT_RX_UNDER] = 1'b1;
        end
        if (req.rd && req.addr == ICR_OFF_RX_OVER_CLEAR) begin
            clr[ICR_BIT_RX_OVER] = 1'b1;
        end
        if (req.rd && req.addr == ICR_OFF_CLR_TX_OVER) begin
            clr[ICR_BIT_TX_OVER] = 1'b1;
        end
    end

    genvar g;
    generate
        for (g = 0; g < ICR_NUM_SRC; g++) begin : g_src
            icr_flag u_flag (
                .i_core_clk(i_core_clk),
                .i_arst_n(i_arst_n),
                .i_set(evt.set[g]),
                .i_clr(clr[g]),
                .o_flag(raw[g])
            );
        end
    endgenerate

    // Mask is the software-steered register; a zero bit hides a source.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mask_q <= ICR_RST_MASK;
        end else if (req.wr && req.addr == ICR_OFF_INTR_MASK) begin
            mask_q <= req.wdata[7:0];
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            abrt_q <= ICR_RST_ABRT;
        end else begin
            abrt_q <= evt.abrt_set | (rd_all ? ICR_RST_ABRT : abrt_q);
        end
    end

    // Registered copies keep every output straight from a flip-flop.
    // They lag the flag cells by one cycle.
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            raw_q <= ICR_RST_RAW;
            intr_q <= 1'b0;
        end else begin
            raw_q <= raw;
            intr_q <= |(raw & mask_q);
        end
    end

    always_comb begin
        rdata_d = ICR_RST_ZERO;
        if (req.rd) begin
            case (req.addr)
                ICR_OFF_RAW_STATUS: rdata_d = {24'h00_0000, raw};
                ICR_OFF_INTR_MASK: rdata_d = {24'h00_0000, mask_q};
                ICR_OFF_ABRT_CAUSE: rdata_d = {16'h0000, abrt_q};
                default: rdata_d = ICR_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rdata_q <= ICR_RST_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign o_rdata = rdata_q;
    assign o_intr = intr_q;
    assign o_raw_status = raw_q;
    assign o_abrt_cause = abrt_q;

    // Named steps shared by the properties below.
    sequence s_quiet;
        evt.set == 8'h00;
    endsequence

    sequence s_clr_all_quiet;
        rd_all && evt.set == 8'h00;
    endsequence

    sequence s_no_read;
        !req.rd;
    endsequence

    sequence s_abrt_quiet;
        !rd_all && evt.abrt_set == 16'h0000;
    endsequence

    property p_raw_copy;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        1'b1 |=> (o_raw_status == $past(raw));
    endproperty
    a_raw_copy: assert property (p_raw_copy)
        else $error("raw status view out of step");

    property p_intr_copy;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        1'b1 |=> (o_intr == $past(|(raw & mask_q)));
    endproperty
    a_intr_copy: assert property (p_intr_copy)
        else $error("combined interrupt out of step");

    property p_mask_write;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (req.wr && req.addr == ICR_OFF_INTR_MASK)
        |=> (mask_q == $past(req.wdata[7:0]));
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write lost");

    property p_clr_all_view;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        s_clr_all_quiet ##1 s_quiet ##1 s_quiet |=> (o_raw_status == 8'h00);
    endproperty
    a_clr_all_view: assert property (p_clr_all_view)
        else $error("raw view kept a source after clear-all");

    property p_abrt_hold;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        s_abrt_quiet |=> (abrt_q == $past(abrt_q));
    endproperty
    a_abrt_hold: assert property (p_abrt_hold)
        else $error("abort cause changed with no cause");

    // A cause that arrives in the clearing cycle must not be lost, so the
    // record then holds exactly the new bits.
    // new cause survives clear
    property p_abrt_race;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (rd_all && evt.abrt_set != 16'h0000)
        |=> (abrt_q == $past(evt.abrt_set));
    endproperty
    a_abrt_race: assert property (p_abrt_race)
        else $error("abort cause wrong after clear race");

    property p_abrt_accum;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (evt.abrt_set != 16'h0000)
        |=> ((abrt_q & $past(evt.abrt_set)) == $past(evt.abrt_set));
    endproperty
    a_abrt_accum: assert property (p_abrt_accum)
        else $error("abort cause bit dropped");

    property p_no_read_keep;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        s_no_read |=> (raw == ($past(raw) | $past(evt.set)));
    endproperty
    a_no_read_keep: assert property (p_no_read_keep)
        else $error("source cleared without a read");

    property p_rdata_idle;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        s_no_read |=> (o_rdata == 32'h0000_0000);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data nonzero without a read");

    property p_zero_rd_rest;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (req.rd && (req.addr == ICR_OFF_RX_UNDER_CLEAR
            || req.addr == ICR_OFF_CLR_TX_OVER)) |=> (o_rdata == 32'h0000_0000);
    endproperty
    a_zero_rd_rest: assert property (p_zero_rd_rest)
        else $error("single clear register read nonzero");

    property p_rxu_set_wins;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (req.rd && req.addr == ICR_OFF_RX_UNDER_CLEAR && evt.set[0]) |=> raw[0];
    endproperty
    a_rxu_set_wins: assert property (p_rxu_set_wins)
        else $error("underflow event lost during clear");

    property p_rxo_set_wins;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (req.rd && req.addr == ICR_OFF_RX_OVER_CLEAR && evt.set[1]) |=> raw[1];
    endproperty
    a_rxo_set_wins: assert property (p_rxo_set_wins)
        else $error("overflow event lost during clear");

    property p_txo_set_wins;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (req.rd && req.addr == ICR_OFF_CLR_TX_OVER && evt.set[3]) |=> raw[3];
    endproperty
    a_txo_set_wins: assert property (p_txo_set_wins)
        else $error("transmit overflow event lost during clear");

    property p_clr_all;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (rd_all && evt.set == 8'h00) |=> (raw == 8'h00);
    endproperty
    a_clr_all: assert property (p_clr_all)
        else $error("clear-all left a source set");

    property p_intr_drop;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        s_clr_all_quiet ##1 s_quiet |=> !o_intr;
    endproperty
    a_intr_drop: assert property (p_intr_drop)
        else $error("combined interrupt stayed after clear-all");

    property p_abrt_clr;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (rd_all && evt.abrt_set == 16'h0000) |=> (o_abrt_cause == 16'h0000);
    endproperty
    a_abrt_clr: assert property (p_abrt_clr)
        else $error("abort cause survived clear-all");

    property p_rxu;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (req.rd && req.addr == ICR_OFF_RX_UNDER_CLEAR && !evt.set[0])
        |=> (!raw[0] && raw[7:1] == ($past(raw[7:1]) | $past(evt.set[7:1])));
    endproperty
    a_rxu: assert property (p_rxu)
        else $error("underflow clear wrong");

    property p_rxo;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (req.rd && req.addr == ICR_OFF_RX_OVER_CLEAR && !evt.set[1])
        |=> (!raw[1] && raw[0] == ($past(raw[0]) | $past(evt.set[0])));
    endproperty
    a_rxo: assert property (p_rxo)
        else $error("overflow clear wrong");

    property p_txo;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (req.rd && req.addr == ICR_OFF_CLR_TX_OVER && !evt.set[3])
        |=> (!raw[3] && raw[2:0] == ($past(raw[2:0]) | $past(evt.set[2:0])));
    endproperty
    a_txo: assert property (p_txo)
        else $error("transmit overflow clear wrong");

    property p_zero_rd;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (req.rd && (req.addr == ICR_OFF_CLR_ALL
            || req.addr == ICR_OFF_RX_OVER_CLEAR)) |=> (o_rdata == 32'h0000_0000);
    endproperty
    a_zero_rd: assert property (p_zero_rd)
        else $error("clear register read nonzero");

    property p_set_wins;
        @(posedge i_core_clk) disable iff (!i_arst_n)
        (rd_all && evt.set[0]) |=> raw[0] ##1 o_raw_status[0];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost during clear");
endmodule : icr_top

// file: tb.sv
// Self-checking bench for the read-to-clear interrupt register group.
// Assumes the register port answers one cycle after the strobe.
`timescale 1ns/1ps
module tb;
    import icr_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] i_src_set = 8'h00;
    logic [15:0] i_abrt_set = 16'h0000;
    logic [31:0] o_rdata;
    logic o_intr;
    logic [7:0] o_raw_status;
    logic [15:0] o_abrt_cause;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    logic [7:0] offs [3] = '{ICR_OFF_RX_UNDER_CLEAR, ICR_OFF_RX_OVER_CLEAR,
        ICR_OFF_CLR_TX_OVER};
    int bits [3] = '{ICR_BIT_RX_UNDER, ICR_BIT_RX_OVER, ICR_BIT_TX_OVER};

    icr_top dut_u (
        .i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_src_set(i_src_set), .i_abrt_set(i_abrt_set), .o_intr(o_intr),
        .o_raw_status(o_raw_status), .o_abrt_cause(o_abrt_cause));

    always #20 i_core_clk = ~i_core_clk;

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    // The whole run needs little more than a hundred cycles; a hang is cut at 3000.
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic chk(input string name, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            n_fail++;
        end
    endtask : chk

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        #1;
        chk("read data", exp, o_rdata);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_wr <= 1'b0;
    endtask : wr

    // Raw status and the combined line both lag a flag change by one edge.
    task automatic settle();
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask : settle

    task automatic fire(input logic [7:0] s, input logic [15:0] ab);
        @(posedge i_core_clk);
        i_src_set <= s;
        i_abrt_set <= ab;
        @(posedge i_core_clk);
        i_src_set <= 8'h00;
        i_abrt_set <= 16'h0000;
        settle();
    endtask : fire

    task automatic t_reset();
        chk("raw", 32'h0, {24'h0, o_raw_status});
        chk("abort", 32'h0, {16'h0, o_abrt_cause});
        rd(ICR_OFF_CLR_ALL, ICR_RST_ZERO);
        foreach (offs[i]) rd(offs[i], ICR_RST_ZERO);
        rd(ICR_OFF_INTR_MASK, {24'h0, ICR_RST_MASK});
    endtask : t_reset

    task automatic t_single();
        foreach (offs[i]) begin
            fire(8'hFF, 16'h0000);
            rd(offs[i], 32'h0);
            settle();
            chk("raw", {24'h0, 8'hFF & ~(8'h01 << bits[i])},
                {24'h0, o_raw_status});
            chk("intr", 32'h1, {31'h0, o_intr});
            rd(ICR_OFF_CLR_ALL, 32'h0);
            settle();
        end
    endtask : t_single

    task automatic t_all();
        fire(8'hFF, 16'hA5C3);
        chk("abort", 32'hA5C3, {16'h0, o_abrt_cause});
        chk("intr", 32'h1, {31'h0, o_intr});
        rd(ICR_OFF_CLR_ALL, 32'h0);
        settle();
        chk("raw", 32'h0, {24'h0, o_raw_status});
        chk("intr", 32'h0, {31'h0, o_intr});
        chk("abort", 32'h0, {16'h0, o_abrt_cause});
    endtask : t_all

    task automatic t_write();
        fire(8'h0B, 16'h0000);
        wr(ICR_OFF_CLR_ALL, 32'hFFFF_FFFF);
        foreach (offs[i]) wr(offs[i], 32'hFFFF_FFFF);
        settle();
        chk("raw", 32'h0B, {24'h0, o_raw_status});
        rd(8'h60, 32'h0);
        rd(ICR_OFF_CLR_ALL, 32'h0);
        settle();
    endtask : t_write

    task automatic t_race();
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= ICR_OFF_CLR_ALL;
        i_src_set <= 8'h01;
        i_abrt_set <= 16'h0001;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        i_src_set <= 8'h00;
        i_abrt_set <= 16'h0000;
        #1;
        chk("read data", 32'h0, o_rdata);
        chk("abort", 32'h1, {16'h0, o_abrt_cause});
        settle();
        chk("raw", 32'h01, {24'h0, o_raw_status});
        chk("intr", 32'h1, {31'h0, o_intr});
        @(posedge i_core_clk);
        i_rd <= 1'b1;
        i_addr <= ICR_OFF_RX_OVER_CLEAR;
        i_src_set <= 8'h02;
        @(posedge i_core_clk);
        i_rd <= 1'b0;
        i_src_set <= 8'h00;
        settle();
        rd(ICR_OFF_RAW_STATUS, 32'h3);
        rd(ICR_OFF_ABRT_CAUSE, 32'h1);
        rd(ICR_OFF_CLR_ALL, 32'h0);
        settle();
        chk("raw", 32'h0, {24'h0, o_raw_status});
        chk("abort", 32'h0, {16'h0, o_abrt_cause});
    endtask : t_race

    task automatic t_mask();
        fire(8'h08, 16'h0000);
        chk("intr", 32'h1, {31'h0, o_intr});
        wr(ICR_OFF_INTR_MASK, 32'h0000_00F7);
        settle();
        chk("intr", 32'h0, {31'h0, o_intr});
        rd(ICR_OFF_INTR_MASK, 32'h0000_00F7);
        rd(ICR_OFF_CLR_TX_OVER, 32'h0);
        settle();
        chk("raw", 32'h0, {24'h0, o_raw_status});
        wr(ICR_OFF_INTR_MASK, {24'h0, ICR_RST_MASK});
        settle();
    endtask : t_mask

    initial begin
        repeat (6) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        @(posedge i_core_clk);
        #1;
        t_reset();
        t_single();
        t_all();
        t_write();
        t_race();
        t_mask();
        end_of_test();
    end
endmodule : tb
